// ==== design/mhp_pkg.sv ====
`default_nettype none
package mhp_pkg;
  // Host port select (low address bits)
  localparam logic [2:0] PORT_CAP_A = 3'h0;
  localparam logic [2:0] PORT_CAP_B = 3'h4;
  localparam logic [2:0] PORT_INDEX = 3'h5;
  localparam logic [2:0] PORT_DATA  = 3'h6;

  // Internal index map
  localparam logic [6:0] IDX_CAP_LAST = 7'h1f;
  localparam logic [6:0] IDX_CFG      = 7'h40;
  localparam logic [6:0] IDX_ST1      = 7'h41;
  localparam logic [6:0] IDX_ST2      = 7'h42;
  localparam logic [6:0] IDX_MGMT_M1  = 7'h43;
  localparam logic [6:0] IDX_MGMT_M2  = 7'h44;
  localparam logic [6:0] IDX_HOST_M1  = 7'h45;
  localparam logic [6:0] IDX_HOST_M2  = 7'h46;
  localparam logic [6:0] IDX_STEP     = 7'h01;

  // Reset values
  localparam logic [7:0] CFG_RST     = 8'h08;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] HOST_M2_RST = 8'h40;
  localparam logic [7:0] ZERO8       = 8'h00;
  localparam logic [6:0] INDEX_RST   = 7'h00;

  // Configuration, mask and status bits
  localparam int CFG_START     = 0;
  localparam int CFG_MGMT_EN   = 1;
  localparam int CFG_HOST_EN   = 2;
  localparam int CFG_INT_CLR   = 3;
  localparam int CFG_RST_PULSE = 4;
  localparam int CFG_HOST_SEL  = 5;
  localparam int CFG_BYPASS    = 6;
  localparam int M2_RST_EN     = 7;
  localparam int ST2_CAP_OVF   = 6;

  // Capture RAM
  localparam int         CAP_DEPTH_N = 32;
  localparam int         CAP_AW      = 5;
  localparam logic [5:0] CAP_DEPTH   = 6'h20;
  localparam logic [5:0] CAP_STEP    = 6'h01;
  localparam logic [5:0] CAP_RST     = 6'h00;

  localparam int CHAIN_PINS = 8;

  // Timing
  localparam int unsigned CLK_FREQ_HZ  = 50_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned RST_PULSE_MS = 20;
  localparam int          PULSE_CW     = 24;

  typedef enum {TMR_IDLE, TMR_LOW} mhp_tmr_e;
endpackage
`default_nettype wire

// ==== design/mhp_pulse_if.sv ====
`default_nettype none
interface mhp_pulse_if;
  logic fire;
  logic active;
  logic done;
  modport ctl (output fire, input active, input done);
  modport tmr (input fire, output active, output done);
endinterface
`default_nettype wire

// ==== design/mhp_pulse_timer.sv ====
`default_nettype none
module mhp_pulse_timer #(
  parameter int unsigned CYC = 1_000_000
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Control
  mhp_pulse_if.tmr     pif
);
  mhp_pkg::mhp_tmr_e             state_q;
  logic [mhp_pkg::PULSE_CW-1:0]  cnt_q;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q    <= mhp_pkg::TMR_IDLE;
      cnt_q      <= '0;
      pif.active <= 1'b0;
      pif.done   <= 1'b0;
    end
    else
    begin
      pif.done <= 1'b0;
      case (state_q)
        mhp_pkg::TMR_IDLE:
        begin
          if (pif.fire)
          begin
            state_q    <= mhp_pkg::TMR_LOW;
            cnt_q      <= mhp_pkg::PULSE_CW'(CYC - 1);
            pif.active <= 1'b1;
          end
        end
        mhp_pkg::TMR_LOW:
        begin
          if (cnt_q == '0)
          begin
            state_q    <= mhp_pkg::TMR_IDLE;
            pif.active <= 1'b0;
            pif.done   <= 1'b1;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default:
        begin
          state_q    <= mhp_pkg::TMR_IDLE;
          pif.active <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== design/mhp_host_port_ctrl.sv ====
// Behaviour
// - Status read returns contents, then clears it.
// - Cleared status stays cleared until loop refresh or capture overflow.
// - Cleared status releases the interrupt outputs.
// - Interrupt-clear bit releases outputs, halts loop.
// - Config bit 6 drives bypass output low.
// - Reset pulse enabled only by mask bit 7.
// - Config bit 4 gives 20 ms low, self-clears.
// - Capture port writes store byte, advance pointer.
// - Over 32 bytes raises interrupt, pointer stops.
// - Capture RAM readable at index 00h-1Fh.
// - Data-port reads use a separate pointer.
// - Test entry plus forced low goes high-Z.
// - Chain output reflects every toggled chain pin.
// - Index bits 6-0 select target, reset 00h.
// - Busy set by index write or serial.
// - Busy cleared by data access or serial end.
// - Capture range index advances, stops at 1Fh.
`default_nettype none
module mhp_host_port_ctrl #(
  parameter int unsigned RST_PULSE_CYC =
    mhp_pkg::CLK_FREQ_HZ / mhp_pkg::MS_PER_S * mhp_pkg::RST_PULSE_MS
) (
  // Clock and reset
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst,
  // Host port
  input  wire logic [2:0]                    i_port_sel,
  input  wire logic                          i_port_wr,
  input  wire logic                          i_port_rd,
  input  wire logic [7:0]                    i_port_wdata,
  output logic      [7:0]                    o_port_rdata,
  // Serial bus activity
  input  wire logic                          i_serial_busy,
  // Monitoring loop
  input  wire logic                          i_loop_done,
  input  wire logic [7:0]                    i_status1_evt,
  input  wire logic [7:0]                    i_status2_evt,
  output logic                               o_loop_run,
  // Interrupt pins
  input  wire logic                          i_system_mgmt_irq_pin,
  output logic                               o_system_mgmt_irq_out,
  output logic                               o_system_mgmt_irq_oe,
  output logic                               o_host_irq_out,
  output logic                               o_host_irq_oe,
  output logic                               o_host_irq_sel,
  // Reset and bypass pins
  output logic                               o_reset_out,
  output logic                               o_reset_oe,
  output logic                               o_pwr_bypass_n,
  // Chain test
  input  wire logic [mhp_pkg::CHAIN_PINS-1:0] i_chain_pins,
  output logic                               o_chain_test_output,
  output logic                               o_pins_hiz
);
  logic [7:0]                    cfg_q;
  logic [7:0]                    st1_q;
  logic [7:0]                    st2_q;
  logic [7:0]                    pend1_q;
  logic [7:0]                    pend2_q;
  logic [7:0]                    mgmt_m1_q;
  logic [7:0]                    mgmt_m2_q;
  logic [7:0]                    host_m1_q;
  logic [7:0]                    host_m2_q;
  logic [6:0]                    idx_q;
  logic                          busy_isa_q;
  logic                          busy_isa_d;
  logic                          busy_q;
  logic [5:0]                    cap_cnt_q;
  logic [7:0]                    cap_ram [mhp_pkg::CAP_DEPTH_N];
  logic [7:0]                    rd_mux;
  logic                          mgmt_s1_q;
  logic                          mgmt_s2_q;
  logic [mhp_pkg::CHAIN_PINS-1:0] chain_s1_q;
  logic [mhp_pkg::CHAIN_PINS-1:0] chain_s2_q;

  mhp_pulse_if pif ();

  mhp_pulse_timer #(
    .CYC (RST_PULSE_CYC)
  ) u_pulse (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .pif       (pif.tmr)
  );

  function automatic logic [6:0] next_index(input logic [6:0] idx);
    logic [6:0] nxt;
    nxt = idx;
    if (idx < mhp_pkg::IDX_CAP_LAST)
      nxt = idx + mhp_pkg::IDX_STEP;
    else if (idx == mhp_pkg::IDX_ST1 || idx == mhp_pkg::IDX_MGMT_M1 ||
             idx == mhp_pkg::IDX_HOST_M1)
      nxt = idx + mhp_pkg::IDX_STEP;
    return nxt;
  endfunction

  function automatic logic is_cap_port(input logic [2:0] sel);
    return (sel == mhp_pkg::PORT_CAP_A) || (sel == mhp_pkg::PORT_CAP_B);
  endfunction

  wire logic data_wr  = i_port_wr && (i_port_sel == mhp_pkg::PORT_DATA);
  wire logic data_rd  = i_port_rd && (i_port_sel == mhp_pkg::PORT_DATA);
  wire logic data_acc = data_wr || data_rd;
  wire logic index_wr = i_port_wr && (i_port_sel == mhp_pkg::PORT_INDEX);
  wire logic cap_wr   = i_port_wr && is_cap_port(i_port_sel);
  wire logic cap_room = cap_cnt_q < mhp_pkg::CAP_DEPTH;
  wire logic cap_ovf  = cap_wr && !cap_room;
  wire logic int_clr  = cfg_q[mhp_pkg::CFG_INT_CLR];
  wire logic rst_en   = mgmt_m2_q[mhp_pkg::M2_RST_EN];
  wire logic cfg_wr   = data_wr && (idx_q == mhp_pkg::IDX_CFG);
  wire logic st1_rd   = data_rd && (idx_q == mhp_pkg::IDX_ST1);
  wire logic st2_rd   = data_rd && (idx_q == mhp_pkg::IDX_ST2);
  wire logic test_entry = !cfg_q[mhp_pkg::CFG_START] && int_clr;

  // Pulse fires only when enabled and idle
  assign pif.fire = cfg_wr && i_port_wdata[mhp_pkg::CFG_RST_PULSE] && rst_en &&
                    !pif.active;

  // Configuration
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      cfg_q <= mhp_pkg::CFG_RST;
    else if (cfg_wr)
    begin
      cfg_q <= i_port_wdata;
      if (!rst_en && !pif.active)
        cfg_q[mhp_pkg::CFG_RST_PULSE] <= 1'b0;
    end
    else if (pif.done)
      cfg_q[mhp_pkg::CFG_RST_PULSE] <= 1'b0;
  end

  // Mask registers
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      mgmt_m1_q <= mhp_pkg::MASK_RST;
      mgmt_m2_q <= mhp_pkg::MASK_RST;
      host_m1_q <= mhp_pkg::MASK_RST;
      host_m2_q <= mhp_pkg::HOST_M2_RST;
    end
    else if (data_wr)
    begin
      if (idx_q == mhp_pkg::IDX_MGMT_M1)
        mgmt_m1_q <= i_port_wdata;
      if (idx_q == mhp_pkg::IDX_MGMT_M2)
        mgmt_m2_q <= i_port_wdata;
      if (idx_q == mhp_pkg::IDX_HOST_M1)
        host_m1_q <= i_port_wdata;
      if (idx_q == mhp_pkg::IDX_HOST_M2)
        host_m2_q <= i_port_wdata;
    end
  end

  // Events gather during a loop pass and land in status at its end
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      pend1_q <= mhp_pkg::ZERO8;
      pend2_q <= mhp_pkg::ZERO8;
    end
    else if (i_loop_done)
    begin
      pend1_q <= mhp_pkg::ZERO8;
      pend2_q <= mhp_pkg::ZERO8;
    end
    else
    begin
      pend1_q <= pend1_q | i_status1_evt;
      pend2_q <= pend2_q | i_status2_evt;
    end
  end

  // Clear on read; a refresh or overflow in the same cycle wins
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      st1_q <= mhp_pkg::ZERO8;
      st2_q <= mhp_pkg::ZERO8;
    end
    else
    begin
      st1_q <= (st1_rd ? mhp_pkg::ZERO8 : st1_q) |
               (i_loop_done ? (pend1_q | i_status1_evt) : mhp_pkg::ZERO8);
      st2_q <= (st2_rd ? mhp_pkg::ZERO8 : st2_q) |
               (i_loop_done ? (pend2_q | i_status2_evt) : mhp_pkg::ZERO8);
      if (cap_ovf)
        st2_q[mhp_pkg::ST2_CAP_OVF] <= 1'b1;
    end
  end

  // Index pointer
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      idx_q <= mhp_pkg::INDEX_RST;
    else if (index_wr)
      idx_q <= i_port_wdata[$bits(idx_q)-1:0];
    else if (data_acc)
      idx_q <= next_index(idx_q);
  end

  // Busy flag
  always_comb
  begin
    busy_isa_d = busy_isa_q;
    if (index_wr)
      busy_isa_d = 1'b1;
    else if (data_acc)
      busy_isa_d = 1'b0;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      busy_isa_q <= 1'b0;
      busy_q     <= 1'b0;
    end
    else
    begin
      busy_isa_q <= busy_isa_d;
      busy_q     <= busy_isa_d || i_serial_busy;
    end
  end

  // Capture write pointer
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      cap_cnt_q <= mhp_pkg::CAP_RST;
    else if (cap_wr && cap_room)
      cap_cnt_q <= cap_cnt_q + mhp_pkg::CAP_STEP;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (cap_wr && cap_room)
      cap_ram[cap_cnt_q[mhp_pkg::CAP_AW-1:0]] <= i_port_wdata;
  end

  always_comb
  begin
    rd_mux = mhp_pkg::ZERO8;
    if (idx_q <= mhp_pkg::IDX_CAP_LAST)
      rd_mux = cap_ram[idx_q[mhp_pkg::CAP_AW-1:0]];
    else
    begin
      case (idx_q)
        mhp_pkg::IDX_CFG:     rd_mux = cfg_q;
        mhp_pkg::IDX_ST1:     rd_mux = st1_q;
        mhp_pkg::IDX_ST2:     rd_mux = st2_q;
        mhp_pkg::IDX_MGMT_M1: rd_mux = mgmt_m1_q;
        mhp_pkg::IDX_MGMT_M2: rd_mux = mgmt_m2_q;
        mhp_pkg::IDX_HOST_M1: rd_mux = host_m1_q;
        mhp_pkg::IDX_HOST_M2: rd_mux = host_m2_q;
        default:              rd_mux = mhp_pkg::ZERO8;
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_port_rdata <= mhp_pkg::ZERO8;
    else if (i_port_rd)
    begin
      if (i_port_sel == mhp_pkg::PORT_INDEX)
        o_port_rdata <= {busy_q, idx_q};
      else if (i_port_sel == mhp_pkg::PORT_DATA)
        o_port_rdata <= rd_mux;
      else
        o_port_rdata <= mhp_pkg::ZERO8;
    end
  end

  // Interrupt outputs; mask bit high blocks its source
  wire logic mgmt_any = |(st1_q & ~mgmt_m1_q) |
                        |(st2_q[mhp_pkg::M2_RST_EN-1:0] & ~mgmt_m2_q[mhp_pkg::M2_RST_EN-1:0]);
  wire logic host_any = |(st1_q & ~host_m1_q) | |(st2_q & ~host_m2_q);

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_system_mgmt_irq_out <= 1'b0;
      o_system_mgmt_irq_oe  <= 1'b0;
      o_host_irq_out        <= 1'b0;
      o_host_irq_oe         <= 1'b0;
      o_host_irq_sel        <= 1'b0;
      o_loop_run            <= 1'b0;
    end
    else
    begin
      o_system_mgmt_irq_oe <= cfg_q[mhp_pkg::CFG_MGMT_EN] && !int_clr &&
                              mgmt_any;
      o_host_irq_oe        <= cfg_q[mhp_pkg::CFG_HOST_EN] && !int_clr &&
                              host_any;
      o_host_irq_sel       <= cfg_q[mhp_pkg::CFG_HOST_SEL];
      o_loop_run           <= cfg_q[mhp_pkg::CFG_START] && !int_clr;
    end
  end

  // Reset and bypass pins
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_reset_out    <= 1'b0;
      o_reset_oe     <= 1'b0;
      o_pwr_bypass_n <= 1'b1;
    end
    else
    begin
      o_reset_out    <= 1'b0;
      o_reset_oe     <= pif.active;
      o_pwr_bypass_n <= !cfg_q[mhp_pkg::CFG_BYPASS];
    end
  end

  // Pin synchronisers
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      mgmt_s1_q  <= 1'b1;
      mgmt_s2_q  <= 1'b1;
      chain_s1_q <= '1;
      chain_s2_q <= '1;
    end
    else
    begin
      mgmt_s1_q  <= i_system_mgmt_irq_pin;
      mgmt_s2_q  <= mgmt_s1_q;
      chain_s1_q <= i_chain_pins;
      chain_s2_q <= chain_s1_q;
    end
  end

  // Chain test
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pins_hiz          <= 1'b0;
      o_chain_test_output <= 1'b0;
    end
    else
    begin
      o_pins_hiz          <= test_entry && !mgmt_s2_q;
      o_chain_test_output <= ~&chain_s2_q;
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence s_pulse_start;
    $rose(o_reset_oe);
  endsequence
  sequence s_pulse_hold;
    o_reset_oe [*8];
  endsequence

  chk_status_clear: assert property (
    (st1_rd && !i_loop_done && !cap_ovf) |=> (st1_q == mhp_pkg::ZERO8))
    else $error("status not cleared by read");
  chk_status_hold: assert property (
    (st1_q == mhp_pkg::ZERO8 && !i_loop_done) |=> (st1_q == mhp_pkg::ZERO8))
    else $error("status refreshed outside loop end");
  chk_irq_release: assert property (
    (st1_q == mhp_pkg::ZERO8 && st2_q == mhp_pkg::ZERO8) |=>
      (!o_system_mgmt_irq_oe && !o_host_irq_oe))
    else $error("interrupt held with empty status");
  chk_loop_halt: assert property (
    int_clr |=> (!o_loop_run && !o_system_mgmt_irq_oe && !o_host_irq_oe))
    else $error("loop or interrupt active under clear");
  chk_bypass_drive: assert property (
    ##1 (o_pwr_bypass_n == !$past(cfg_q[mhp_pkg::CFG_BYPASS])))
    else $error("bypass pin mismatch");
  chk_pulse_enable: assert property (
    (!rst_en && !pif.active) |=> ##1 !o_reset_oe)
    else $error("reset pulse without enable");
  chk_pulse_width: assert property (
    s_pulse_start |-> s_pulse_hold)
    else $error("reset pulse too short");
  chk_cap_advance: assert property (
    (cap_wr && cap_room) |=> (cap_cnt_q == $past(cap_cnt_q) + mhp_pkg::CAP_STEP))
    else $error("capture pointer did not advance");
  chk_cap_overflow: assert property (
    cap_ovf |=> (cap_cnt_q == mhp_pkg::CAP_DEPTH && st2_q[mhp_pkg::ST2_CAP_OVF]))
    else $error("capture overflow mishandled");
  chk_index_stop: assert property (
    (data_acc && idx_q == mhp_pkg::IDX_CAP_LAST) |=> (idx_q == mhp_pkg::IDX_CAP_LAST))
    else $error("index passed capture top");
  chk_busy_set: assert property (
    index_wr |=> busy_q)
    else $error("busy not set by index write");
  chk_busy_clear: assert property (
    (data_acc && !i_serial_busy) |=> !busy_q)
    else $error("busy not cleared by data access");
  chk_test_hiz: assert property (
    (test_entry && !mgmt_s2_q) |=> o_pins_hiz)
    else $error("test entry did not float pins");
  chk_chain_out: assert property (
    $changed(chain_s2_q) && $onehot(chain_s2_q ^ $past(chain_s2_q)) |=>
      (o_chain_test_output == ~&$past(chain_s2_q)))
    else $error("chain toggle not reflected");
endmodule
`default_nettype wire

// ==== sim/mhp_host_model.sv ====
`default_nettype none
module mhp_host_model (
  // Clock
  input  wire logic       i_clk_sys,
  // Host port
  input  wire logic [7:0] i_rdata,
  output var  logic [2:0] o_sel,
  output var  logic       o_wr,
  output var  logic       o_rd,
  output var  logic [7:0] o_wdata,
  // Serial master and monitoring loop
  output var  logic       o_serial_busy,
  output var  logic       o_loop_done,
  output var  logic [7:0] o_evt1,
  output var  logic [7:0] o_evt2
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_sel = 3'h7;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
    o_serial_busy = 1'b0;
    o_loop_done = 1'b0;
    o_evt1 = 8'h00;
    o_evt2 = 8'h00;
  end

  // One strobe cycle, then the data line shows the inverse of the last byte
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_sel = sel;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask

  task automatic rd(input logic [2:0] sel, output logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_sel = sel;
    o_rd = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_rd = 1'b0;
    d = i_rdata;
  endtask

  // Passes are spaced by the caller; status reads between passes see no refresh
  task automatic loop_pass(input logic [7:0] e1, input logic [7:0] e2);
    @(posedge i_clk_sys);
    #1;
    o_evt1 = e1;
    o_evt2 = e2;
    o_loop_done = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_evt1 = 8'h00;
    o_evt2 = 8'h00;
    o_loop_done = 1'b0;
  endtask

  // Only called between parallel accesses, never overlapping them
  task automatic serial(input logic b);
    @(posedge i_clk_sys);
    #1;
    o_serial_busy = b;
  endtask
endmodule
`default_nettype wire

// ==== sim/mhp_host_port_ctrl_test.sv ====
`default_nettype none
module mhp_host_port_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PCYC = 16;

  logic       clk, rst, wr, rd, sbusy, ldone, force_low, run, m_oe, r_oe, byp_n, ch_out, hiz;
  logic       h_oe, h_sel, m_out, h_out, r_out;
  logic [2:0] sel;
  logic [7:0] wdata, rdata, evt1, evt2, pins, d;
  wire        mgmt_pin = ~(m_oe | force_low);
  int         err_count, checks, n, i;

  mhp_host_port_ctrl #(.RST_PULSE_CYC(PCYC)) i_mhp_host_port_ctrl (
    .i_clk_sys(clk), .i_rst(rst), .i_port_sel(sel), .i_port_wr(wr), .i_port_rd(rd),
    .i_port_wdata(wdata), .o_port_rdata(rdata), .i_serial_busy(sbusy),
    .i_loop_done(ldone), .i_status1_evt(evt1), .i_status2_evt(evt2), .o_loop_run(run),
    .i_system_mgmt_irq_pin(mgmt_pin), .o_system_mgmt_irq_out(m_out),
    .o_system_mgmt_irq_oe(m_oe), .o_host_irq_out(h_out), .o_host_irq_oe(h_oe),
    .o_host_irq_sel(h_sel), .o_reset_out(r_out), .o_reset_oe(r_oe), .o_pwr_bypass_n(byp_n),
    .i_chain_pins(pins), .o_chain_test_output(ch_out), .o_pins_hiz(hiz));

  mhp_host_model i_mhp_host_model (
    .i_clk_sys(clk), .i_rdata(rdata), .o_sel(sel), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
    .o_serial_busy(sbusy), .o_loop_done(ldone), .o_evt1(evt1), .o_evt2(evt2));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [6:0] idx, input logic [7:0] v);
    i_mhp_host_model.wr(mhp_pkg::PORT_INDEX, {1'b0, idx});
    i_mhp_host_model.wr(mhp_pkg::PORT_DATA, v);
  endtask

  task automatic reg_rd(input logic [6:0] idx, output logic [7:0] v);
    i_mhp_host_model.wr(mhp_pkg::PORT_INDEX, {1'b0, idx});
    i_mhp_host_model.rd(mhp_pkg::PORT_DATA, v);
  endtask

  initial
  begin
    rst = 1'b1;
    force_low = 1'b0;
    pins = 8'hff;
    err_count = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    check("bypass_rst", {7'h00, byp_n}, 8'h01);
    check("run_rst", {7'h00, run}, 8'h00);
    i_mhp_host_model.rd(mhp_pkg::PORT_INDEX, d);
    check("index_rst", d, 8'h00);
    // Busy from an index write, cleared by the data access
    i_mhp_host_model.wr(mhp_pkg::PORT_INDEX, 8'h41);
    i_mhp_host_model.rd(mhp_pkg::PORT_INDEX, d);
    check("busy_set", d, 8'hc1);
    i_mhp_host_model.rd(mhp_pkg::PORT_DATA, d);
    i_mhp_host_model.rd(mhp_pkg::PORT_INDEX, d);
    check("busy_clr", d, 8'h42);
    i_mhp_host_model.serial(1'b1);
    cyc(2);
    i_mhp_host_model.rd(mhp_pkg::PORT_INDEX, d);
    check("busy_ser", d, 8'hc2);
    i_mhp_host_model.serial(1'b0);
    cyc(2);
    i_mhp_host_model.rd(mhp_pkg::PORT_INDEX, d);
    check("busy_ser_end", d, 8'h42);
    // Paired mask registers: a data write steps the index to the second one
    reg_wr(mhp_pkg::IDX_HOST_M1, 8'h80);
    i_mhp_host_model.rd(mhp_pkg::PORT_DATA, d);
    check("host_m2_rst", d, 8'h40);
    reg_rd(mhp_pkg::IDX_HOST_M1, d);
    check("host_m1", d, 8'h80);
    // Capture port: 33 writes alternating both ports
    for (i = 0; i < 33; i++)
      i_mhp_host_model.wr(i[0] ? mhp_pkg::PORT_CAP_B : mhp_pkg::PORT_CAP_A, 8'(i) ^ 8'h5a);
    i_mhp_host_model.wr(mhp_pkg::PORT_INDEX, 8'h00);
    for (i = 0; i < 33; i++)
    begin
      i_mhp_host_model.rd(mhp_pkg::PORT_DATA, d);
      check("cap_byte", d, 8'(i > 31 ? 31 : i) ^ 8'h5a);
    end
    i_mhp_host_model.rd(mhp_pkg::PORT_INDEX, d);
    check("cap_idx_top", d, 8'h1f);
    reg_rd(mhp_pkg::IDX_ST2, d);
    check("cap_ovf", d, 8'h40);
    reg_rd(mhp_pkg::IDX_ST2, d);
    check("st2_cleared", d, 8'h00);
    // Status clearing and interrupt release
    reg_wr(mhp_pkg::IDX_CFG, 8'h27);
    i_mhp_host_model.loop_pass(8'h01, 8'h00);
    cyc(3);
    check("irq_set", {7'h00, m_oe}, 8'h01);
    check("host_irq_set", {6'h00, h_oe, h_sel}, 8'h03);
    check("irq_data_low", {6'h00, m_out, h_out}, 8'h00);
    reg_rd(mhp_pkg::IDX_ST1, d);
    check("st1_read", d, 8'h01);
    cyc(2);
    check("irq_rel", {7'h00, m_oe}, 8'h00);
    check("host_irq_rel", {7'h00, h_oe}, 8'h00);
    reg_rd(mhp_pkg::IDX_ST1, d);
    check("st1_cleared", d, 8'h00);
    i_mhp_host_model.loop_pass(8'h01, 8'h00);
    cyc(3);
    reg_wr(mhp_pkg::IDX_CFG, 8'h0b);
    cyc(2);
    check("intclr_irq", {7'h00, m_oe}, 8'h00);
    check("intclr_host", {7'h00, h_oe}, 8'h00);
    check("intclr_run", {7'h00, run}, 8'h00);
    reg_rd(mhp_pkg::IDX_ST1, d);
    check("intclr_keep", d, 8'h01);
    reg_wr(mhp_pkg::IDX_CFG, 8'h43);
    cyc(2);
    check("run_resume", {7'h00, run}, 8'h01);
    check("bypass_on", {7'h00, byp_n}, 8'h00);
    reg_wr(mhp_pkg::IDX_CFG, 8'h13);
    cyc(2);
    check("bypass_off", {7'h00, byp_n}, 8'h01);
    check("rst_blocked", {7'h00, r_oe}, 8'h00);
    reg_rd(mhp_pkg::IDX_CFG, d);
    check("cfg_blocked", d, 8'h03);
    // Timed reset pulse once enabled
    reg_wr(mhp_pkg::IDX_MGMT_M2, 8'h80);
    reg_wr(mhp_pkg::IDX_CFG, 8'h13);
    for (i = 0; i < 10 && r_oe !== 1'b1; i++)
      cyc(1);
    check("rst_drive", {7'h00, r_out}, 8'h00);
    n = 0;
    for (i = 0; i < 100 && r_oe === 1'b1; i++)
    begin
      n++;
      cyc(1);
    end
    if (i == 100 || n == 0)
    begin
      err_count++;
      summarize();
    end
    check("pulse_len", 8'(n), 8'(PCYC));
    reg_rd(mhp_pkg::IDX_CFG, d);
    check("pulse_selfclr", d, 8'h03);
    // Chain test entry: start low, interrupt-clear high, then pull the pin low
    reg_wr(mhp_pkg::IDX_CFG, 8'h08);
    cyc(4);
    check("hiz_off", {7'h00, hiz}, 8'h00);
    force_low = 1'b1;
    cyc(4);
    check("hiz_on", {7'h00, hiz}, 8'h01);
    check("chain_ones", {7'h00, ch_out}, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      pins = ~(8'h01 << i);
      cyc(4);
      check("chain_tog", {7'h00, ch_out}, 8'h01);
      pins = 8'hff;
      cyc(4);
      check("chain_back", {7'h00, ch_out}, 8'h00);
    end
    summarize();
  end
endmodule
`default_nettype wire
